//--- core/rcr_params.svh
// Purpose : Constants for the reset cause recorder.
// Assumes : Included by its bare name from the package and the core.
// Notes   : Widths, offsets, field positions, masks and reset images only.
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// ==========================================================================
// Widths and vectors
`define RCR_PC_W           15
`define RCR_RESET_VECTOR   15'h0000
`define RCR_IRQ_VECTOR     15'h0004
`define RCR_PC_STEP        15'h0001

// ==========================================================================
// Reset-cause register fields (bits 5:4 unimplemented, read as zero)
`define RCR_CAUSE_W        8
`define RCR_BIT_STK_OVF    7
`define RCR_BIT_STK_UNF    6
`define RCR_BIT_EXT_PIN    3
`define RCR_BIT_RST_INSTR  2
`define RCR_BIT_POWERON    1
`define RCR_BIT_BROWNOUT   0
`define RCR_CAUSE_IMPL     8'hcf
`define RCR_CAUSE_POR_IMG  8'h0c

// ==========================================================================
// Status image fields: timeout, powerdown, then three arithmetic flags
`define RCR_STATUS_W       5
`define RCR_STATUS_POR_IMG 5'h18

// ==========================================================================
// Event input positions
`define RCR_EV_W           8
`define RCR_EV_POR         0
`define RCR_EV_BOR         1
`define RCR_EV_WDT         2
`define RCR_EV_PIN         3
`define RCR_EV_INSTR       4
`define RCR_EV_OVF         5
`define RCR_EV_UNF         6
`define RCR_EV_IRQ         7
`define RCR_SYNC_W         5

`endif

//--- core/rcr_pkg.sv
// Purpose : Types for the reset cause recorder.
// Assumes : Constants come from rcr_params.svh.
// Notes   : Holds no numbers of its own besides the enum codes.
`include "rcr_params.svh"

package rcr_pkg;

   // =======================================================================
   // Selected event, one per cycle
   typedef enum logic [3:0] {
      RCR_EV_NONE      = 4'h0,
      RCR_EV_POWERON   = 4'h1,
      RCR_EV_BROWNOUT  = 4'h2,
      RCR_EV_PIN_RUN   = 4'h3,
      RCR_EV_PIN_SLEEP = 4'h4,
      RCR_EV_WDT_RST   = 4'h5,
      RCR_EV_WDT_WAKE  = 4'h6,
      RCR_EV_STK_OVF   = 4'h7,
      RCR_EV_STK_UNF   = 4'h8,
      RCR_EV_INSTR     = 4'h9,
      RCR_EV_IRQ_WAKE  = 4'ha
   } rcr_event_t;

   // =======================================================================
   // Core run state as seen by the recorder
   typedef enum logic [1:0] {
      RCR_ST_RUN    = 2'b00,
      RCR_ST_SLEEP  = 2'b01,
      RCR_ST_VECTOR = 2'b10
   } rcr_state_t;

endpackage : rcr_pkg

//--- core/rcr_event_sel.sv
// Purpose : Priority selection of one reset or wake event per cycle.
// Assumes : Event inputs are single-cycle pulses on clk_i.
// Notes   : Purely combinational; the core registers the result.
`timescale 1ns/100ps
`include "rcr_params.svh"

module rcr_event_sel (
   input  wire logic [`RCR_EV_W-1:0] ev_i,      // Event pulses
   input  wire logic                 asleep_i,  // Core is sleeping
   input  wire logic                 stk_en_i,  // Stack error reset enabled
   output rcr_pkg::rcr_event_t       sel_o      // Winning event
);

   // =======================================================================
   // Power loss outranks everything, the interrupt wake ranks last; watchdog wake outranks stack errors
   always_comb begin
      sel_o = rcr_pkg::RCR_EV_NONE;
      if (ev_i[`RCR_EV_POR]) begin
         sel_o = rcr_pkg::RCR_EV_POWERON;
      end else if (ev_i[`RCR_EV_BOR]) begin
         sel_o = rcr_pkg::RCR_EV_BROWNOUT;
      end else if (ev_i[`RCR_EV_PIN]) begin
         sel_o = asleep_i ? rcr_pkg::RCR_EV_PIN_SLEEP : rcr_pkg::RCR_EV_PIN_RUN;
      end else if (ev_i[`RCR_EV_WDT]) begin
         sel_o = asleep_i ? rcr_pkg::RCR_EV_WDT_WAKE : rcr_pkg::RCR_EV_WDT_RST;
      end else if (ev_i[`RCR_EV_OVF] && stk_en_i) begin
         sel_o = rcr_pkg::RCR_EV_STK_OVF;
      end else if (ev_i[`RCR_EV_UNF] && stk_en_i) begin
         sel_o = rcr_pkg::RCR_EV_STK_UNF;
      end else if (ev_i[`RCR_EV_INSTR] && !asleep_i) begin
         sel_o = rcr_pkg::RCR_EV_INSTR;
      end else if (ev_i[`RCR_EV_IRQ] && asleep_i) begin
         sel_o = rcr_pkg::RCR_EV_IRQ_WAKE;
      end
   end

endmodule : rcr_event_sel

//--- core/rcr_top.sv
// Purpose : Records the cause of the last reset or wake and sets restart state.
// Assumes : Power, watchdog, pin and wake inputs are asynchronous to clk_i.
// Notes   : Core-side inputs share clk_i and are used unsynchronised.
`timescale 1ns/100ps
`include "rcr_params.svh"

module rcr_top (
   input  wire logic                     clk_i,          // 50 MHz system clock
   input  wire logic                     rst_n_i,        // Async reset, active low
   input  wire logic                     poweron_i,      // Power-on request, async
   input  wire logic                     brownout_i,     // Brown-out request, async
   input  wire logic                     watchdog_i,     // Watchdog expiry, async
   input  wire logic                     master_clear_pin_n_i, // Reset pin, low active
   input  wire logic                     irq_wake_i,     // Wake interrupt, async
   input  wire logic                     reset_instr_i,  // Reset instruction pulse
   input  wire logic                     stk_overflow_i, // Stack overflow pulse
   input  wire logic                     stk_underflow_i,// Stack underflow pulse
   input  wire logic                     stack_error_reset_enable_i, // Stack reset enable
   input  wire logic                     global_irq_enable_i, // Interrupt enable
   input  wire logic                     sleep_req_i,    // Sleep instruction pulse
   input  wire logic                     instr_done_i,   // Instruction retired pulse
   input  wire logic [`RCR_PC_W-1:0]     pc_i,           // Current program counter
   input  wire logic                     cause_wr_i,     // Software write strobe
   input  wire logic [`RCR_CAUSE_W-1:0]  cause_wr_data_i,// Software write data
   output logic [`RCR_CAUSE_W-1:0]       reset_cause_register_o, // Cause flags
   output logic                          timeout_flag_o, // Status timeout flag
   output logic                          powerdown_flag_o, // Status powerdown flag
   output logic                          arith_clear_o,  // Clear status low bits
   output logic                          core_reset_o,   // Core restart pulse
   output logic                          pc_load_o,      // Load program counter
   output logic [`RCR_PC_W-1:0]          pc_target_o,    // Program counter value
   output logic                          push_o,         // Push return address
   output logic [`RCR_PC_W-1:0]          push_addr_o,    // Return address
   output logic                          asleep_o        // Core held in sleep
);

   // =======================================================================
   // Input synchronisers
   logic [`RCR_SYNC_W-1:0] sync1_r, sync1_nxt;
   logic [`RCR_SYNC_W-1:0] sync2_r, sync2_nxt;
   logic [`RCR_SYNC_W-1:0] prev_r,  prev_nxt;
   logic [`RCR_SYNC_W-1:0] raw_lvl;
   logic [`RCR_SYNC_W-1:0] rise;

   // Pin is inverted first so all five are rising-edge events
   assign raw_lvl = {irq_wake_i, ~master_clear_pin_n_i, watchdog_i, brownout_i, poweron_i};

   // Two stages; only stage two and its delayed copy feed the edge detect
   always_comb begin
      sync1_nxt = raw_lvl;
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r  <= prev_nxt;
      end
   end

   assign rise = sync2_r & ~prev_r;

   // =======================================================================
   // Event gathering and selection
   logic [`RCR_EV_W-1:0] ev_vec;
   rcr_pkg::rcr_event_t  ev_sel;
   rcr_pkg::rcr_state_t  state_r, state_nxt;

   always_comb begin
      ev_vec                = '0;
      ev_vec[`RCR_EV_POR]   = rise[0];
      ev_vec[`RCR_EV_BOR]   = rise[1];
      ev_vec[`RCR_EV_WDT]   = rise[2];
      ev_vec[`RCR_EV_PIN]   = rise[3];
      ev_vec[`RCR_EV_IRQ]   = rise[4];
      ev_vec[`RCR_EV_INSTR] = reset_instr_i;
      ev_vec[`RCR_EV_OVF]   = stk_overflow_i;
      ev_vec[`RCR_EV_UNF]   = stk_underflow_i;
   end

   rcr_event_sel u_sel (
      .ev_i     (ev_vec),
      .asleep_i (state_r == rcr_pkg::RCR_ST_SLEEP),
      .stk_en_i (stack_error_reset_enable_i),
      .sel_o    (ev_sel)
   );

   // =======================================================================
   // Next program counter
   function automatic logic [`RCR_PC_W-1:0] next_pc(input logic [`RCR_PC_W-1:0] pc);
      next_pc = pc + `RCR_PC_STEP;
   endfunction : next_pc

   // =======================================================================
   // Flag, program counter and state update
   logic [`RCR_CAUSE_W-1:0] cause_r, cause_nxt;
   logic                    to_r, to_nxt;
   logic                    pd_r, pd_nxt;
   logic                    aclr_r, aclr_nxt;
   logic                    crst_r, crst_nxt;
   logic                    pcld_r, pcld_nxt;
   logic [`RCR_PC_W-1:0]    pct_r, pct_nxt;
   logic                    push_r, push_nxt;
   logic [`RCR_PC_W-1:0]    pusha_r, pusha_nxt;
   logic [`RCR_PC_W-1:0]    ret_r, ret_nxt;
   logic                    asleep_r, asleep_nxt;

   // Software write first, then the hardware event so the hardware event wins the cycle
   always_comb begin
      cause_nxt = cause_r;
      to_nxt    = to_r;
      pd_nxt    = pd_r;
      aclr_nxt  = 1'b0;
      crst_nxt  = 1'b0;
      pcld_nxt  = 1'b0;
      pct_nxt   = pct_r;
      push_nxt  = 1'b0;
      pusha_nxt = pusha_r;
      ret_nxt   = ret_r;
      state_nxt = state_r;
      if (cause_wr_i) begin
         cause_nxt = cause_wr_data_i;
      end
      if (state_r == rcr_pkg::RCR_ST_RUN && sleep_req_i) begin
         state_nxt = rcr_pkg::RCR_ST_SLEEP;
      end
      if (state_r == rcr_pkg::RCR_ST_VECTOR && instr_done_i) begin
         push_nxt  = 1'b1;
         pusha_nxt = ret_r;
         pcld_nxt  = 1'b1;
         pct_nxt   = `RCR_IRQ_VECTOR;
         state_nxt = rcr_pkg::RCR_ST_RUN;
      end
      case (ev_sel)
         rcr_pkg::RCR_EV_POWERON: begin
            cause_nxt = `RCR_CAUSE_POR_IMG;
            {to_nxt, pd_nxt} = 2'b11;
            aclr_nxt = 1'b1;
         end
         rcr_pkg::RCR_EV_BROWNOUT: begin
            cause_nxt[`RCR_BIT_STK_OVF]   = 1'b0;
            cause_nxt[`RCR_BIT_STK_UNF]   = 1'b0;
            cause_nxt[`RCR_BIT_EXT_PIN]   = 1'b1;
            cause_nxt[`RCR_BIT_RST_INSTR] = 1'b1;
            cause_nxt[`RCR_BIT_BROWNOUT]  = 1'b0;
            {to_nxt, pd_nxt} = 2'b11;
         end
         rcr_pkg::RCR_EV_PIN_RUN: begin
            cause_nxt[`RCR_BIT_EXT_PIN] = 1'b0;
         end
         rcr_pkg::RCR_EV_PIN_SLEEP: begin
            cause_nxt[`RCR_BIT_EXT_PIN] = 1'b0;
            {to_nxt, pd_nxt} = 2'b10;
         end
         rcr_pkg::RCR_EV_WDT_RST: begin
            to_nxt = 1'b0;
         end
         rcr_pkg::RCR_EV_WDT_WAKE: begin
            {to_nxt, pd_nxt} = 2'b00;
         end
         rcr_pkg::RCR_EV_STK_OVF: begin
            cause_nxt[`RCR_BIT_STK_OVF] = 1'b1;
         end
         rcr_pkg::RCR_EV_STK_UNF: begin
            cause_nxt[`RCR_BIT_STK_UNF] = 1'b1;
         end
         rcr_pkg::RCR_EV_INSTR: begin
            cause_nxt[`RCR_BIT_RST_INSTR] = 1'b0;
         end
         rcr_pkg::RCR_EV_IRQ_WAKE: begin
            {to_nxt, pd_nxt} = 2'b10;
         end
         default: begin
         end
      endcase
      // Restarting events share the same program counter handling
      case (ev_sel)
         rcr_pkg::RCR_EV_NONE: begin
         end
         rcr_pkg::RCR_EV_WDT_WAKE, rcr_pkg::RCR_EV_IRQ_WAKE: begin
            pcld_nxt  = 1'b1;
            push_nxt  = 1'b0;
            pct_nxt   = next_pc(pc_i);
            ret_nxt   = next_pc(next_pc(pc_i));
            state_nxt = (ev_sel == rcr_pkg::RCR_EV_IRQ_WAKE && global_irq_enable_i)
                      ? rcr_pkg::RCR_ST_VECTOR : rcr_pkg::RCR_ST_RUN;
         end
         default: begin
            crst_nxt  = 1'b1;
            pcld_nxt  = 1'b1;
            push_nxt  = 1'b0;
            pct_nxt   = `RCR_RESET_VECTOR;
            state_nxt = rcr_pkg::RCR_ST_RUN;
         end
      endcase
      cause_nxt = cause_nxt & `RCR_CAUSE_IMPL;
      asleep_nxt = (state_nxt == rcr_pkg::RCR_ST_SLEEP);
   end

   // Reset state is the power-on image
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_r <= `RCR_CAUSE_POR_IMG;
         to_r    <= 1'(`RCR_STATUS_POR_IMG >> 4);
         asleep_r <= 1'b0;
         pd_r    <= 1'b1;
         aclr_r  <= 1'b0;
         crst_r  <= 1'b0;
         pcld_r  <= 1'b0;
         pct_r   <= `RCR_RESET_VECTOR;
         push_r  <= 1'b0;
         pusha_r <= `RCR_RESET_VECTOR;
         ret_r   <= `RCR_RESET_VECTOR;
         state_r <= rcr_pkg::RCR_ST_RUN;
      end else begin
         cause_r <= cause_nxt;
         to_r    <= to_nxt;
         pd_r    <= pd_nxt;
         aclr_r  <= aclr_nxt;
         crst_r  <= crst_nxt;
         pcld_r  <= pcld_nxt;
         pct_r   <= pct_nxt;
         push_r  <= push_nxt;
         pusha_r <= pusha_nxt;
         ret_r   <= ret_nxt;
         state_r <= state_nxt;
         asleep_r <= asleep_nxt;
      end
   end

   // =======================================================================
   // Outputs, all straight from flip-flops
   assign reset_cause_register_o = cause_r;
   assign timeout_flag_o         = to_r;
   assign powerdown_flag_o       = pd_r;
   assign arith_clear_o          = aclr_r;
   assign core_reset_o           = crst_r;
   assign pc_load_o              = pcld_r;
   assign pc_target_o            = pct_r;
   assign push_o                 = push_r;
   assign push_addr_o            = pusha_r;
   assign asleep_o               = asleep_r;

   // =======================================================================
   // Checks
   sequence s_irq_wake_en;
      ev_sel == rcr_pkg::RCR_EV_IRQ_WAKE && global_irq_enable_i;
   endsequence

   sequence s_vector_jump;
      ##1 (pc_load_o && state_r == rcr_pkg::RCR_ST_VECTOR)
      ##[1:300] (push_o && pc_target_o == `RCR_IRQ_VECTOR);
   endsequence

   power_on_image_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_POWERON |=> cause_r == 8'h0c && pc_target_o == 15'h0000
      && core_reset_o)
      else $error("power-on image wrong");

   power_on_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_POWERON |=> timeout_flag_o && powerdown_flag_o)
      else $error("power-on left timeout or powerdown clear");

   brownout_image_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_BROWNOUT |=> (cause_r & 8'hcd) == 8'h0c
      && (cause_r[1] == $past(cause_r[1]) || $past(cause_wr_i))
      && timeout_flag_o && powerdown_flag_o)
      else $error("brown-out image wrong");

   wdt_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_WDT_RST && !cause_wr_i |=> !timeout_flag_o
      && $stable(powerdown_flag_o) && $stable(cause_r) && pc_target_o == 15'h0000)
      else $error("watchdog reset handling wrong");

   wake_resume_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_WDT_WAKE |=> !timeout_flag_o && !powerdown_flag_o
      && pc_load_o && !core_reset_o && pc_target_o == $past(pc_i) + 15'h0001)
      else $error("watchdog wake handling wrong");

   irq_wake_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_IRQ_WAKE |=> timeout_flag_o && !powerdown_flag_o
      && !core_reset_o && pc_target_o == $past(pc_i) + 15'h0001)
      else $error("interrupt wake handling wrong");

   irq_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_irq_wake_en ##0 (1'b1 ##1 (instr_done_i && ev_sel == rcr_pkg::RCR_EV_NONE))
      |=> push_o && pc_target_o == 15'h0004 && push_addr_o == $past(pc_i, 2)
      + 15'h0002)
      else $error("interrupt vector jump wrong");

   vector_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_irq_wake_en |-> s_vector_jump)
      else $error("interrupt vector entry missing");

   pin_sleep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_sel == rcr_pkg::RCR_EV_PIN_SLEEP |=> !cause_r[3] && timeout_flag_o
      && !powerdown_flag_o && core_reset_o)
      else $error("pin reset in sleep wrong");

   stack_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ev_sel == rcr_pkg::RCR_EV_STK_OVF || ev_sel == rcr_pkg::RCR_EV_STK_UNF)
      |=> (cause_r[7] || $past(ev_sel) == rcr_pkg::RCR_EV_STK_UNF)
      && (cause_r[6] || $past(ev_sel) == rcr_pkg::RCR_EV_STK_OVF)
      && core_reset_o ##1 !core_reset_o)
      else $error("stack error reset wrong");

   unimpl_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      reset_cause_register_o[5:4] == 2'b00)
      else $error("unimplemented cause bits not zero");

endmodule : rcr_top

//--- testbench/rcr_src_model.sv
// Purpose : Power, watchdog, pin and wake sources for the recorder.
// Assumes : One event per rising edge of go_i.
// Notes   : Lines drop again after four cycles so each event is an edge.
`timescale 1ns/100ps

module rcr_src_model (
   input  wire logic       clk_i,     // System clock
   input  wire logic       go_i,      // Start one event
   input  wire logic [2:0] kind_i,    // 0 por 1 bor 2 wdt 3 pin 4 irq
   output logic            poweron_o, // Power-on request
   output logic            brown_o,   // Brown-out request
   output logic            wdog_o,    // Watchdog expiry
   output logic            pin_n_o,   // Reset pin, low active
   output logic            irq_o      // Wake interrupt
);
   // ======================================================================
   // Idle levels, pin pulled high when nobody pushes it
   initial begin
      {poweron_o, brown_o, wdog_o, irq_o} = 4'h0;
      pin_n_o = 1'b1;
   end

   // Off-clock timing, like a real asynchronous source
   always @(posedge go_i) begin
      case (kind_i)
         3'h0: poweron_o = 1'b1;
         3'h1: brown_o = 1'b1;
         3'h2: wdog_o = 1'b1;
         3'h3: pin_n_o = 1'b0;
         default: irq_o = 1'b1;
      endcase
      repeat (4) @(negedge clk_i);
      {poweron_o, brown_o, wdog_o, irq_o} = 4'h0;
      pin_n_o = 1'b1;
   end
endmodule : rcr_src_model

//--- testbench/rcr_top_tb.sv
// Purpose : Self-checking bench for the reset cause recorder.
// Assumes : Inputs change on the falling edge; seed fixed.
// Notes   : Expected flags are tracked in cause_e, to_e and pd_e.
`timescale 1ns/100ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end

module rcr_top_tb;
   logic        clk_i = 0, rst_n_i = 0, go = 0, sleep_req_i = 0, instr_done_i = 0;
   logic        reset_instr_i = 0, stk_overflow_i = 0, stk_underflow_i = 0;
   logic        stk_en = 1, global_irq_enable = 0, cause_wr_i = 0;
   logic [2:0]  kind = 0;
   logic [14:0] pc_i = 0, pc_target_o, push_addr_o;
   logic [7:0]  cause_wr_data_i = 0, cause_o, cause_e = 8'h0c;
   logic        to_o, pd_o, arith_o, core_reset_o, pc_load_o, push_o, asleep_o;
   logic        to_e = 1, pd_e = 1;
   wire         por_w, bor_w, wdt_w, pin_n_w, irq_w;
   int          n_fail = 0, check_count = 0;

   // ======================================================================
   // Clock, partner and design
   always #10 clk_i = ~clk_i;

   rcr_src_model rcr_src_model_i (.clk_i(clk_i), .go_i(go), .kind_i(kind),
      .poweron_o(por_w), .brown_o(bor_w), .wdog_o(wdt_w), .pin_n_o(pin_n_w), .irq_o(irq_w));

   rcr_top rcr_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .poweron_i(por_w),
      .brownout_i(bor_w), .watchdog_i(wdt_w), .master_clear_pin_n_i(pin_n_w),
      .irq_wake_i(irq_w), .reset_instr_i(reset_instr_i), .stk_overflow_i(stk_overflow_i),
      .stk_underflow_i(stk_underflow_i), .stack_error_reset_enable_i(stk_en),
      .global_irq_enable_i(global_irq_enable), .sleep_req_i(sleep_req_i), .instr_done_i(instr_done_i),
      .pc_i(pc_i), .cause_wr_i(cause_wr_i), .cause_wr_data_i(cause_wr_data_i),
      .reset_cause_register_o(cause_o), .timeout_flag_o(to_o), .powerdown_flag_o(pd_o),
      .arith_clear_o(arith_o), .core_reset_o(core_reset_o), .pc_load_o(pc_load_o),
      .pc_target_o(pc_target_o), .push_o(push_o), .push_addr_o(push_addr_o),
      .asleep_o(asleep_o));

   // ======================================================================
   // Tasks: closing report, one-cycle pulses, bounded waits
   task end_sim;
      $display("Checks %0d, errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic pulse(input int w);
      @(negedge clk_i);
      {cause_wr_i, go, sleep_req_i, instr_done_i, stk_underflow_i, stk_overflow_i,
       reset_instr_i} <= 7'h01 << w;
      @(negedge clk_i);
      {cause_wr_i, go, sleep_req_i, instr_done_i, stk_underflow_i, stk_overflow_i,
       reset_instr_i} <= 7'h00;
   endtask : pulse

   // Never open-ended: a lost answer ends the run
   task automatic wt(input int sel);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_i);
         #1;
         if ((sel == 0 ? pc_load_o : sel == 1 ? push_o : asleep_o) === 1'b1)
            return;
      end
      n_fail++;
      $display("Error %0t: no answer %0d", $time, sel);
      end_sim;
   endtask : wt

   task automatic wr(input logic [7:0] d);
      cause_wr_data_i <= d;
      pulse(6);
      cause_e = d & 8'hcf;
      `CHK(cause_o, cause_e)
   endtask : wr

   // One event with its expected flags and restart address
   task automatic ev(input int k, input logic slp);
      logic wake;
      wake = 1'b0;
      pc_i <= 15'($urandom);
      if (slp) begin
         pulse(4);
         wt(2);
      end
      case (k)
         0: begin cause_e = 8'h0c; to_e = 1; pd_e = 1; end
         1: begin cause_e = (cause_e & 8'h02) | 8'h0c; to_e = 1; pd_e = 1; end
         2: begin to_e = 0; if (slp) begin pd_e = 0; wake = 1; end end
         3: begin cause_e[3] = 0; if (slp) begin to_e = 1; pd_e = 0; end end
         4: begin to_e = 1; pd_e = 0; wake = 1; end
         5: cause_e[2] = 0;
         6: cause_e[7] = 1;
         default: cause_e[6] = 1;
      endcase
      kind <= 3'(k);
      // Core pulses answer inside the pulse, so look while the answer stands
      if (k < 5) begin
         pulse(5);
         wt(0);
      end else begin
         pulse(k - 5);
      end
      `CHK(pc_load_o, 1'b1)
      `CHK(arith_o, k == 0)
      `CHK(cause_o, cause_e)
      `CHK({to_o, pd_o}, {to_e, pd_e})
      `CHK(pc_target_o, wake ? 15'(pc_i + 15'h1) : 15'h0)
      `CHK(core_reset_o, !wake)
      if (k == 4 && global_irq_enable) begin
         pulse(3);
         `CHK(push_o, 1'b1)
         `CHK({push_addr_o, pc_target_o}, {15'(pc_i + 15'h2), 15'h0004})
      end
      repeat (6) @(negedge clk_i);
   endtask : ev

   // ======================================================================
   // Main sequence: fixed cases, random mix, disabled stack errors
   initial begin
      int k;
      void'($urandom(32'h70d0));
      repeat (10) @(negedge clk_i);
      rst_n_i <= 1;
      @(posedge clk_i);
      #1;
      `CHK({cause_o, to_o, pd_o, pc_target_o}, {8'h0c, 2'b11, 15'h0})
      wr(8'hff);
      for (int i = 0; i < 10; i++)
         ev(i % 8, i == 4 || i > 7);
      for (int i = 0; i < 40; i++) begin
         k = $urandom_range(7);
         global_irq_enable <= 1'($urandom);
         if (i % 5 == 0)
            wr(8'($urandom));
         ev(k, k == 4 || ((k == 2 || k == 3) && $urandom_range(1)));
      end
      stk_en <= 0;
      pulse(1);
      k = int'(pc_load_o === 1'b1);
      pulse(2);
      k += int'(pc_load_o === 1'b1);
      repeat (8) begin
         @(posedge clk_i);
         #1;
         k += int'(pc_load_o === 1'b1);
      end
      `CHK(k, 0)
      `CHK(cause_o, cause_e)
      end_sim;
   end
endmodule : rcr_top_tb
